/* tsi_pkg.sv */
// Shared types, rates, timing constants and rate and buffer-index helpers for the slot interchange
package tsi_pkg;

  typedef enum logic [1:0] {
    RATE_2M = 2'h0,
    RATE_4M = 2'h1,
    RATE_8M = 2'h2
  } rate_e;

  typedef enum logic {
    LOCK_SEARCH = 1'b0,
    LOCK_RUN    = 1'b1
  } lock_e;

  typedef struct packed {
    rate_e      in_rate;
    rate_e      out_rate;
    logic [1:0] out_pair;
  } cfg_s;

  typedef struct packed {
    logic       enable;
    logic [2:0] delay;
  } ioff_s;

  typedef struct packed {
    logic       we;
    logic [6:0] chan;
    logic [6:0] src;
    logic       vc;
  } cm_wr_s;

  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned FRAME_NS     = 125000;
  localparam int unsigned SLOT_2M_NS   = 3900;
  localparam int unsigned SLOT_4M_NS   = 1950;
  localparam int unsigned SLOT_8M_NS   = 975;
  localparam int unsigned FRAME_CYC    = FRAME_NS / CLK_NS;
  localparam int unsigned LOCK_LOSS_FRAMES = 2;
  localparam int unsigned CHANS_2M     = FRAME_NS / SLOT_2M_NS;
  localparam int unsigned CHANS_4M     = FRAME_NS / SLOT_4M_NS;
  localparam int unsigned CHANS_8M     = FRAME_NS / SLOT_8M_NS;
  localparam logic [2:0]  MAX_OFFSET   = 3'h4;
  localparam logic        VC_VARIABLE  = 1'b0;
  localparam logic [9:0]  MASK_SLOW    = 10'h1FF;
  localparam logic [9:0]  MASK_FAST    = 10'h3FF;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  // One-slot widths per rate in 128ths of a frame
  localparam logic [4:0]  W_2M         = 5'(128 / CHANS_2M);
  localparam logic [4:0]  W_4M         = 5'(128 / CHANS_4M);
  localparam logic [4:0]  W_8M         = 5'(128 / CHANS_8M);

  function automatic logic [1:0] rate_log(input rate_e r);
    return (r == RATE_8M) ? 2'h2 : ((r == RATE_4M) ? 2'h1 : 2'h0);
  endfunction : rate_log

  function automatic logic [1:0] inc3(input logic [1:0] b);
    return (b == 2'h2) ? 2'h0 : 2'(b + 2'h1);
  endfunction : inc3

endpackage : tsi_pkg

/* tsi_switch.sv */
// Serial slot interchange with input sampling offset and per-channel delay modes
`timescale 1ns/1ns

// Operation
// - Sampling offset only takes effect at 4.096 or 8.192 Mb/s input rates.
// - Enabled offset postpones input sampling by at most four link clock periods.
// - Offset creates a virtual input frame aligned to the arriving data.
// - Output frames stay aligned to the frame pulse whatever the offset.
// - Per-channel mode bit selects delay mode; zero means variable delay.
// - Same-rate variable delay depends on channel numbers only, not streams.
// - Same-rate minimum delay is three, five or nine slots per rate.
// - Beyond the minimum, delay is output minus input channel, under a frame.
// - At 2.048 Mb/s wrap to previous frame unless m is n+3 or later.
// - At 4.096 Mb/s wrap to previous frame unless m is n+5 or later.
// - At 8.192 Mb/s wrap to previous frame unless m exceeds n+8.
// - Differing rates may make delay depend on the output stream pair.
// - 2 to 4 Mb/s delay spans five 4M slots to frame plus four.
// - 2 to 8 Mb/s delay spans nine 8M slots to frame plus eight.
// - 4 to 2 Mb/s minimum is three 2M slots, or two plus one 4M slot.
// - 8 to 2 Mb/s minimum is three 2M slots, or two plus three/two/one 8M.
// - Delay figures are taken when the output channel has fully shifted out.
// - Delay arithmetic uses 125 us frames and 3.9/1.95/0.975 us slots.
// - Constant-delay channels emit frame N input in output frame N+2.
module tsi_switch
  import tsi_pkg::*;
#(
  parameter int unsigned LOCK_LOSS_CYC = LOCK_LOSS_FRAMES * FRAME_CYC
) (
  input  wire logic   CLK_IN,
  input  wire logic   RST_B_IN,
  input  wire logic   LINK_CLK_IN,
  input  wire logic   FRAME_PULSE_INPUT_B_IN,
  input  wire logic   SER_DATA_IN,
  input  wire cfg_s   CFG_IN,
  input  wire ioff_s  INPUT_OFFSET_REGISTER_IN,
  input  wire cm_wr_s CM_WR_IN,
  output logic        SER_DATA_OUT,
  output logic        SER_DATA_OE_OUT,
  output logic        VIRT_FRAME_OUT,
  output logic        LOCKED_OUT
);

  // Pin synchronisers; the second stage feeds logic, and the link clock's third stage also feeds edge detection
  logic [2:0] lclk_q;
  logic [1:0] fp_q;
  logic [1:0] din_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      lclk_q <= 3'h0;
      fp_q   <= 2'h3;
      din_q  <= 2'h0;
    end else begin
      lclk_q <= {lclk_q[1], lclk_q[0], LINK_CLK_IN};
      fp_q   <= {fp_q[0], FRAME_PULSE_INPUT_B_IN};
      din_q  <= {din_q[0], SER_DATA_IN};
    end
  end

  logic link_edge;
  logic fp_low;
  assign link_edge = lclk_q[1] & ~lclk_q[2];
  assign fp_low    = ~fp_q[1];

  // Frame geometry
  logic       fast;
  logic [9:0] mask;
  logic [2:0] sh_in;
  logic [2:0] sh_out;
  logic [9:0] lm_in;
  logic [9:0] lm_out;

  function automatic logic [2:0] tick_shift(input rate_e r, input logic f);
    return 3'((f ? 2'h2 : 2'h1) - rate_log(r));
  endfunction : tick_shift

  function automatic logic [9:0] low_mask(input logic [2:0] s);
    return 10'((10'h1 << s) - 10'h1);
  endfunction : low_mask

  assign fast   = (CFG_IN.in_rate == RATE_8M) || (CFG_IN.out_rate == RATE_8M);
  assign mask   = fast ? MASK_FAST : MASK_SLOW;
  assign sh_in  = tick_shift(CFG_IN.in_rate, fast);
  assign sh_out = tick_shift(CFG_IN.out_rate, fast);
  assign lm_in  = low_mask(sh_in);
  assign lm_out = low_mask(sh_out);

  // Effective sampling offset
  logic [2:0] off_eff;
  always_comb begin
    off_eff = 3'h0;
    if (INPUT_OFFSET_REGISTER_IN.enable && CFG_IN.in_rate != RATE_2M) begin
      off_eff = (INPUT_OFFSET_REGISTER_IN.delay > MAX_OFFSET) ? MAX_OFFSET
                : INPUT_OFFSET_REGISTER_IN.delay;
    end
  end

  // Tick counter locked to the frame pulse
  logic [9:0] tick_q;
  logic [9:0] tnext;
  logic [9:0] vt;
  assign tnext = fp_low ? 10'h0 : (10'(tick_q + 10'h1) & mask);
  assign vt    = 10'(tnext - 10'(off_eff)) & mask;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      tick_q <= 10'h0;
    end else if (link_edge) begin
      tick_q <= tnext;
    end
  end

  // Frame pulse watchdog
  // Sized from the parameter so a long timeout can never wrap to a short one
  localparam int unsigned WD_W = $clog2(LOCK_LOSS_CYC + 1);
  lock_e           lock_q;
  logic [WD_W-1:0] wd_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      wd_q   <= '0;
      lock_q <= LOCK_SEARCH;
    end else begin
      if (link_edge && fp_low) begin
        wd_q <= '0;
      end else if (wd_q != WD_W'(LOCK_LOSS_CYC)) begin
        wd_q <= WD_W'(wd_q + 1'b1);
      end
      case (lock_q)
        LOCK_SEARCH: begin
          if (link_edge && fp_low) begin
            lock_q <= LOCK_RUN;
          end
        end
        LOCK_RUN: begin
          if (wd_q == WD_W'(LOCK_LOSS_CYC)) begin
            lock_q <= LOCK_SEARCH;
          end
        end
        default: begin
          lock_q <= LOCK_SEARCH;
        end
      endcase
    end
  end

  // Input side: virtual frame timing
  logic       in_last;
  logic [2:0] in_bit;
  logic [6:0] in_chan;
  logic [1:0] in_buf_q;
  logic [6:0] in_sh_q;
  logic       vframe_q;
  logic [7:0] dmem_q [3][128];

  assign in_last = (vt & lm_in) == lm_in;
  assign in_bit  = 3'(vt >> sh_in);
  assign in_chan = 7'(vt >> (sh_in + 3'h3));

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      in_buf_q <= 2'h0;
      vframe_q <= 1'b0;
    end else begin
      vframe_q <= link_edge && (vt == 10'h0);
      if (link_edge && vt == 10'h0) begin
        in_buf_q <= inc3(in_buf_q);
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      in_sh_q <= 7'h0;
    end else if (link_edge && in_last) begin
      in_sh_q <= {in_sh_q[5:0], din_q[1]};
    end
  end

  // Data memory keeps three frames so constant-delay reads never collide with writes
  // Cleared at reset so slots not yet written shift out as zeros, never unknowns
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < 3; i++) begin
        for (int j = 0; j < 128; j++) begin
          dmem_q[i][j] <= 8'h0;
        end
      end
    end else if (link_edge && in_last && in_bit == LAST_BIT) begin
      dmem_q[in_buf_q][in_chan] <= {in_sh_q, din_q[1]};
    end
  end

  // Connection memory: source channel and delay mode per output channel
  logic [6:0] cm_src_q [128];
  logic       cm_vc_q  [128];

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < 128; i++) begin
        cm_src_q[i] <= 7'h0;
        cm_vc_q[i]  <= VC_VARIABLE;
      end
    end else if (CM_WR_IN.we) begin
      cm_src_q[CM_WR_IN.chan] <= CM_WR_IN.src;
      cm_vc_q[CM_WR_IN.chan]  <= CM_WR_IN.vc;
    end
  end

  // Minimum variable delay in 128ths of a frame
  function automatic logic [4:0] min_delay(input cfg_s c);
    logic [4:0] t;
    t = 5'h0;
    case ({c.in_rate, c.out_rate})
      {RATE_2M, RATE_2M}: t = 5'(3 * W_2M);
      {RATE_4M, RATE_4M}: t = 5'(5 * W_4M);
      {RATE_8M, RATE_8M}: t = 5'(9 * W_8M);
      {RATE_2M, RATE_4M}: t = 5'(5 * W_4M);
      {RATE_2M, RATE_8M}: t = 5'(9 * W_8M);
      {RATE_4M, RATE_2M}: begin
        t = (c.out_pair == 2'h2) ? 5'(2 * W_2M + W_4M) : 5'(3 * W_2M);
      end
      {RATE_8M, RATE_2M}: begin
        case (c.out_pair)
          2'h1:    t = 5'(2 * W_2M + 3 * W_8M);
          2'h2:    t = 5'(2 * W_2M + 2 * W_8M);
          2'h3:    t = 5'(2 * W_2M + W_8M);
          default: t = 5'(3 * W_2M);
        endcase
      end
      default: t = 5'(3 * W_2M);
    endcase
    return t;
  endfunction : min_delay

  function automatic logic [7:0] pos128(input logic [6:0] ch, input rate_e r);
    return 8'({1'b0, ch} << (2'h2 - rate_log(r)));
  endfunction : pos128

  // Output side: frame-pulse timing
  logic       out_first;
  logic [2:0] out_bit;
  logic [6:0] out_chan;
  logic       load;
  logic [1:0] out_buf_q;
  logic [6:0] src;
  logic       vc;
  logic [4:0] thr;
  logic signed [8:0] diff;
  logic       use_cur;
  logic [1:0] rd_buf;
  logic [7:0] rd_byte;

  assign out_first = (tnext & lm_out) == 10'h0;
  assign out_bit   = 3'(tnext >> sh_out);
  assign out_chan  = 7'(tnext >> (sh_out + 3'h3));
  assign load      = link_edge && out_first && out_bit == 3'h0;
  assign src       = cm_src_q[out_chan];
  assign vc        = cm_vc_q[out_chan];
  assign thr       = min_delay(CFG_IN);
  // Channel positions only, so the stream carrying either end never matters to diff; out_pair acts only through thr
  assign diff      = $signed({1'b0, pos128(out_chan, CFG_IN.out_rate)}) -
                     $signed({1'b0, pos128(src, CFG_IN.in_rate)});
  assign use_cur   = diff >= $signed({4'h0, thr});

  always_comb begin
    if (vc != VC_VARIABLE) begin
      rd_buf = inc3(out_buf_q);
    end else if (use_cur) begin
      rd_buf = out_buf_q;
    end else begin
      rd_buf = inc3(inc3(out_buf_q));
    end
  end

  assign rd_byte = dmem_q[rd_buf][src];

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      out_buf_q <= 2'h0;
    end else if (link_edge && tnext == 10'h0) begin
      out_buf_q <= inc3(out_buf_q);
    end
  end

  // The byte leaves MSB first; its last bit ends where delay is measured
  logic       sto_q;
  logic [6:0] osh_q;
  logic       oe_q;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      sto_q <= 1'b0;
      osh_q <= 7'h0;
    end else if (load) begin
      sto_q <= rd_byte[7];
      osh_q <= rd_byte[6:0];
    end else if (link_edge && out_first) begin
      sto_q <= osh_q[6];
      osh_q <= {osh_q[5:0], 1'b0};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (lock_q == LOCK_RUN);
    end
  end

  assign SER_DATA_OUT    = sto_q;
  assign SER_DATA_OE_OUT = oe_q;
  assign VIRT_FRAME_OUT  = vframe_q;
  assign LOCKED_OUT      = (lock_q == LOCK_RUN);

  a_offset_rate_gate: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (CFG_IN.in_rate == RATE_2M) |-> (off_eff == 3'h0))
    else $error("offset applied at 2 Mb/s input rate");

  a_offset_bound: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    INPUT_OFFSET_REGISTER_IN.enable |-> (off_eff <= MAX_OFFSET))
    else $error("sampling offset exceeds four periods");

  a_virt_frame_skew: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (link_edge && vt == 10'h0) |=> VIRT_FRAME_OUT && (tick_q == 10'(off_eff)))
    else $error("virtual frame not offset from frame pulse");

  a_out_frame_align: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (link_edge && fp_low) |=> (tick_q == 10'h0) ##1 (tick_q == 10'h0))
    else $error("output frame not aligned to frame pulse");

  a_const_two_frames: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (load && vc != VC_VARIABLE) |-> (rd_buf == inc3(out_buf_q)) && (rd_buf != out_buf_q))
    else $error("constant channel not read from frame N-2");

  a_var_wrap: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (load && vc == VC_VARIABLE && diff < $signed({4'h0, thr}))
      |-> (rd_buf == inc3(inc3(out_buf_q))))
    else $error("short separation not taken from previous frame");

  a_same_rate_min: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (CFG_IN.in_rate == CFG_IN.out_rate) |->
      (thr == ((CFG_IN.in_rate == RATE_2M) ? 5'hC : (CFG_IN.in_rate == RATE_4M) ? 5'hA : 5'h9)))
    else $error("wrong same-rate minimum delay");

  a_msb_first: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    load |=> (SER_DATA_OUT == $past(rd_byte[7])) ##1 (osh_q == $past(rd_byte[6:0], 2)))
    else $error("output byte not shifted MSB first");

  a_oe_follows_lock: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (lock_q == LOCK_SEARCH) |=> !SER_DATA_OE_OUT)
    else $error("output driven without frame lock");

endmodule : tsi_switch

/* bp_model.sv */
// Backplane stream model: free-running link clock, frame pulse and skewed serial input
`timescale 1ns/1ns
module bp_model (
  input  int   tpb_in,
  input  int   tpf_in,
  input  int   off_in,
  input  logic fp_en_in,
  output logic link_out,
  output logic fp_b_out,
  output logic sd_out,
  output int   tick_out,
  output int   frame_out
);
  int         vt;
  logic [7:0] b;

  // Frame number is folded in so that a byte from the wrong frame is caught
  function automatic logic [7:0] pat(input int f, input int c);
    return 8'(c * 3 + f * 77 + 90);
  endfunction : pat

  initial begin
    link_out = 1'b0;
    sd_out = 1'b0;
    fp_b_out = 1'b1;
    tick_out = 0;
    frame_out = 2;
    // Phase offset keeps link edges clear of the system clock edges
    #13;
    forever begin
      fp_b_out = !(fp_en_in && tick_out == 0);
      // Skewed stream: data lags the frame pulse by off_in link periods
      vt = frame_out * tpf_in + tick_out - off_in;
      b = pat(vt / tpf_in, (vt % tpf_in) / (8 * tpb_in));
      sd_out = b[7 - (vt % tpf_in) / tpb_in % 8];
      #200 link_out = 1'b1;
      #200 link_out = 1'b0;
      tick_out = (tick_out + 1) % tpf_in;
      if (tick_out == 0) frame_out++;
    end
  end
endmodule : bp_model

/* tb_top.sv */
// Self-checking bench: sets rates, offset and connections, checks switched bytes
`timescale 1ns/1ns
module tb_top;
  import tsi_pkg::*;
  logic       clk, rst_b, sdo, oe, vfr, lkd, link, fp_b, sdi, fp_en;
  logic [7:0] sh;
  cfg_s       cfg;
  ioff_s      ioff;
  cm_wr_s     cm;
  int         tpbi, tpbo, tpf, off, tk, fr, f0, vtk, k, m, fo, d, w, miscompares, checks;
  int         src [128];
  logic       vcs [128];

  tsi_switch #(.LOCK_LOSS_CYC(8400)) dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .LINK_CLK_IN(link), .FRAME_PULSE_INPUT_B_IN(fp_b),
    .SER_DATA_IN(sdi), .CFG_IN(cfg), .INPUT_OFFSET_REGISTER_IN(ioff), .CM_WR_IN(cm),
    .SER_DATA_OUT(sdo), .SER_DATA_OE_OUT(oe), .VIRT_FRAME_OUT(vfr), .LOCKED_OUT(lkd));
  bp_model bp (
    .tpb_in(tpbi), .tpf_in(tpf), .off_in(off), .fp_en_in(fp_en), .link_out(link),
    .fp_b_out(fp_b), .sd_out(sdi), .tick_out(tk), .frame_out(fr));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_up(input logic ok);
    if (!ok) begin
      miscompares++;
      $display("ERROR %0t wait timed out", $time);
      complete_run();
    end
  endtask : give_up

  function automatic int tpb(input rate_e r, input logic fast);
    return r == RATE_2M ? (fast ? 4 : 2) : 1;
  endfunction : tpb

  function automatic int pos(input int c, input rate_e r);
    return c * (r == RATE_2M ? 4 : (r == RATE_4M ? 2 : 1));
  endfunction : pos

  // Least distance, in 128ths of a frame, that still reads the current frame
  function automatic int mn();
    if (cfg.out_rate != RATE_2M) return cfg.out_rate == RATE_4M ? 10 : 9;
    if (cfg.in_rate == RATE_4M) return cfg.out_pair == 2'h2 ? 10 : 12;
    return cfg.in_rate == RATE_8M ? 12 - int'(cfg.out_pair) : 12;
  endfunction : mn

  task automatic cm_write(input int ch, input int s, input logic vc);
    src[ch] = s;
    vcs[ch] = vc;
    @(posedge clk);
    cm <= '{1'b1, 7'(ch), 7'(s), vc};
    @(posedge clk);
    cm.we <= 1'b0;
  endtask : cm_write

  // Switches only just after a frame wrap, so the partner and the switch agree on rates
  task automatic setup(input rate_e ir, input rate_e orr, input logic [1:0] pr,
                       input ioff_s io, input int o);
    logic fast;
    int   i;
    fast = ir == RATE_8M || orr == RATE_8M;
    for (i = 0; i < 20000 && !(tk == 0 && link == 1'b0); i++) @(posedge clk);
    give_up(i < 20000);
    vtk = -1;
    foreach (src[j]) src[j] = -1;
    tpbi = tpb(ir, fast);
    tpbo = tpb(orr, fast);
    tpf = fast ? 1024 : 512;
    off = o;
    cfg <= '{ir, orr, pr};
    ioff <= io;
    f0 = fr;
  endtask : setup

  task automatic run(input int n, input int vexp);
    int i;
    for (i = 0; i < 40000 && fr < f0 + n; i++) @(posedge clk);
    give_up(i < 40000);
    check(8'(vtk), 8'(vexp));
    check({6'h0, lkd, oe}, 8'h3);
  endtask : run

  // Link tick at which the virtual frame pulse was seen
  always @(posedge clk) begin
    if (vfr === 1'b1) vtk <= (tk + tpf - (link ? 0 : 1)) % tpf;
  end

  // A byte is judged at the link edge after its last bit, once fully shifted out
  always @(posedge link) begin
    if (tk % tpbo == 0) begin
      k = (tk == 0 ? tpf : tk) / tpbo - 1;
      fo = tk == 0 ? fr - 1 : fr;
      m = k / 8;
      sh = {sh[6:0], sdo};
      if (k % 8 == 7 && src[m] >= 0 && fo > f0 + int'(vcs[m])) begin
        d = vcs[m] ? 2 : ((pos(m, cfg.out_rate) - pos(src[m], cfg.in_rate) >= mn()) ? 0 : 1);
        check(sh, bp.pat(fo - d, src[m]));
        check({7'h0, oe}, 8'h1);
      end
    end
  end

  initial begin
    rst_b = 1'b0;
    fp_en = 1'b1;
    cfg = '{RATE_2M, RATE_2M, 2'h0};
    ioff = '0;
    cm = '0;
    tpbi = 2;
    tpbo = 2;
    tpf = 512;
    off = 0;
    f0 = 1 << 30;
    vtk = -1;
    miscompares = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    check({4'h0, lkd, oe, vfr, sdo}, 8'h0);
    rst_b <= 1'b1;
    setup(RATE_2M, RATE_2M, 2'h0, '{1'b1, 3'h3}, 0);
    cm_write(5, 2, 1'b0);
    cm_write(4, 2, 1'b0);
    cm_write(1, 30, 1'b0);
    cm_write(31, 0, 1'b0);
    cm_write(10, 20, 1'b1);
    run(3, 0);
    setup(RATE_4M, RATE_4M, 2'h0, '{1'b1, 3'h6}, 4);
    cm_write(10, 5, 1'b0);
    cm_write(9, 5, 1'b0);
    cm_write(2, 60, 1'b0);
    run(2, 4);
    setup(RATE_8M, RATE_8M, 2'h0, '{1'b0, 3'h2}, 0);
    cm_write(20, 11, 1'b0);
    cm_write(19, 11, 1'b0);
    run(2, 0);
    setup(RATE_2M, RATE_4M, 2'h0, '0, 0);
    cm_write(11, 3, 1'b0);
    cm_write(10, 3, 1'b0);
    run(2, 0);
    setup(RATE_4M, RATE_2M, 2'h2, '0, 0);
    cm_write(5, 5, 1'b0);
    cm_write(4, 4, 1'b0);
    run(2, 0);
    setup(RATE_8M, RATE_2M, 2'h1, '0, 0);
    cm_write(5, 9, 1'b0);
    cm_write(6, 14, 1'b0);
    run(2, 0);
    // Frame pulse withdrawn: the watchdog must drop lock and the output driver
    f0 = 1 << 30;
    fp_en = 1'b0;
    for (w = 0; w < 9000 && lkd !== 1'b0; w++) @(posedge clk);
    give_up(w < 9000);
    repeat (2) @(posedge clk);
    check({6'h0, lkd, oe}, 8'h0);
    complete_run();
  end
endmodule : tb_top
